// [core/bbr_pkg.sv]
// bbr_pkg: register map, field layout, reset values and codes for the
// buck3 voltage and boost converter register bank.
// assumes a single 10 MHz clock domain and an AXI4-Lite register master.
`default_nettype none
package bbr_pkg;
   // printed offsets are register indices; byte address is four times this
   localparam logic [15:0] IDX_BUCK3_ON     = 16'h4062;
   localparam logic [15:0] IDX_BUCK3_SLEEP  = 16'h4063;
   localparam logic [15:0] IDX_BOOST_CTRL   = 16'h4064;
   localparam logic [15:0] IDX_BOOST_SLEEP  = 16'h4065;
   localparam logic [15:0] IDX_KEY          = 16'h4070;
   localparam logic [15:0] IDX_INT_STATUS   = 16'h4071;
   localparam logic [15:0] IDX_INT_MASK     = 16'h4072;
   localparam logic [15:0] IDX_STATUS       = 16'h4073;
   localparam int          ADDR_W           = 18;

   localparam logic [15:0] USER_KEY         = 16'h9716;
   localparam logic [6:0]  VCODE_MAX        = 7'h65;
   localparam int unsigned V_BASE_MV        = 850;
   localparam int unsigned V_STEP_MV        = 25;

   localparam logic [15:0] BUCK3_ON_MASK    = 16'h007F;
   localparam logic [15:0] BUCK3_SLEEP_MASK = 16'h007F;
   localparam logic [15:0] BOOST_CTRL_MASK  = 16'hD90D;
   localparam logic [15:0] BOOST_SLEEP_MASK = 16'h0100;
   localparam logic [15:0] BOOST_CTRL_RST   = 16'h0104;
   localparam logic [15:0] ZERO16           = 16'h0000;
   localparam int          ERR_LSB          = 14;
   localparam int          SRC_LSB          = 11;
   localparam int          MODE_BIT         = 8;
   localparam int          RANGE_LSB        = 2;
   localparam int          FB_BIT           = 0;
   localparam int          SLPEN_BIT        = 8;
   localparam logic [15:0] RANGE_FIELD      = 16'h000C;

   typedef enum logic [1:0] {
      ERR_IGNORE   = 2'b00,
      ERR_SHUTDOWN = 2'b01,
      ERR_RESET    = 2'b10,
      ERR_RSVD     = 2'b11
   } bbr_err_e;

   typedef enum logic [1:0] {
      SRC_NONE = 2'b00,
      SRC_HW1  = 2'b01,
      SRC_HW2  = 2'b10,
      SRC_ANY  = 2'b11
   } bbr_src_e;

   typedef enum logic [1:0] {
      AX_IDLE = 2'b00,
      AX_RESP = 2'b01
   } bbr_ax_e;

   typedef struct packed {
      bbr_err_e   error_action;
      bbr_src_e   hw_control_source;
      logic       hw_control_mode;
      logic [1:0] output_range;
      logic       feedback_source;
   } bbr_boost_cfg_s;
endpackage : bbr_pkg
`default_nettype wire

// [core/bbr_regs.sv]
// bbr_regs: AXI4-Lite register bank for buck3 voltage codes and boost control.
// assumes asynchronous pin inputs are external and pass a two-stage sync here;
// nonvolatile start-up code for buck3 arrives on a strap input.
// How it works
// (RULE1) buck3 on code: 0.85V plus 25mV per step
// (RULE2) codes 66h..7Fh saturate at 3.4V
// (RULE3) only bits 6:2 load from startup store
// (RULE4) sleep code bits 6:0, reset zero, same map
// (RULE5) error action: ignore, boost off, device reset
// (RULE6) every undervoltage event raises an interrupt
// (RULE7) hw source: none, in1, in2, either
// (RULE8) hw mode 1 forces off on source
// (RULE9) range bits 3:2 reset to 01
// (RULE10) range writes need user key unlock first
// (RULE11) feedback bit 0: sink 1 or 2
// (RULE12) sleep enable bit 8, reset 0
// (RULE13) undefined bits read zero; fields reset defaults
//
// Local design decision: register access over AXI4-Lite.
`default_nettype none
module bbr_regs
   import bbr_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              srst_i,
   input  wire logic [ADDR_W-1:0] s_awaddr_i,
   input  wire logic              s_awvalid_i,
   output logic                   s_awready_o,
   input  wire logic [31:0]       s_wdata_i,
   input  wire logic [3:0]        s_wstrb_i,
   input  wire logic              s_wvalid_i,
   output logic                   s_wready_o,
   output logic [1:0]             s_bresp_o,
   output logic                   s_bvalid_o,
   input  wire logic              s_bready_i,
   input  wire logic [ADDR_W-1:0] s_araddr_i,
   input  wire logic              s_arvalid_i,
   output logic                   s_arready_o,
   output logic [31:0]            s_rdata_o,
   output logic [1:0]             s_rresp_o,
   output logic                   s_rvalid_o,
   input  wire logic              s_rready_i,
   input  wire logic [4:0]        nv_on_code_i,
   input  wire logic              hw_control_1_i,
   input  wire logic              hw_control_2_i,
   input  wire logic              boost_uv_i,
   input  wire logic              sleep_i,
   output logic [6:0]             buck3_on_voltage_code_o,
   output logic [11:0]            buck3_on_mv_o,
   output logic [11:0]            buck3_sleep_mv_o,
   output logic [1:0]             boost_output_range_o,
   output logic                   boost_feedback_source_o,
   output logic                   boost_on_o,
   output logic                   device_reset_o,
   output logic                   irq_o
);

   function automatic logic [11:0] code_to_mv(input logic [6:0] code);
      logic [6:0] sat;
      sat = (code > VCODE_MAX) ? 7'(VCODE_MAX + 7'h01) : code;    // [RULE2]
      return 12'(V_BASE_MV + V_STEP_MV * sat);                       // [RULE1] [RULE4]
   endfunction : code_to_mv

   ////////////////////////////////////////////////////////////////////////
   // synchronisers
   logic [1:0] hw1_s, hw2_s, uv_s, slp_s;
   logic       uv_d;
   // the strap is read once, but it may still settle late against the clock
   logic [4:0] nv_s1, nv_s2;
   always_ff @(posedge ref_clk_i) begin
      nv_s1 <= nv_on_code_i;
      nv_s2 <= nv_s1;
      hw1_s <= {hw1_s[0], hw_control_1_i};
      hw2_s <= {hw2_s[0], hw_control_2_i};
      uv_s  <= {uv_s[0], boost_uv_i};
      slp_s <= {slp_s[0], sleep_i};
      uv_d  <= uv_s[1];
   end
   wire uv_event = uv_s[1] & ~uv_d;

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [6:0]     buck3_on_voltage_code;
   logic [6:0]     buck3_sleep_voltage_code;
   bbr_boost_cfg_s boost_cfg;
   logic           boost_sleep_enable;
   logic           boost_software_enable;
   logic           key_unlocked;
   logic [1:0]     int_status;
   logic [1:0]     int_mask;
   logic           boost_uv_shutdown;
   logic           strap_done;

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave; one write and one read outstanding, single-beat
   bbr_ax_e        wr_st, rd_st;
   logic           aw_held, w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0]    w_data;
   logic [3:0]     w_strb;

   assign s_awready_o = (wr_st == AX_IDLE) & ~aw_held;
   assign s_wready_o  = (wr_st == AX_IDLE) & ~w_held;
   assign s_arready_o = (rd_st == AX_IDLE);
   assign s_bvalid_o  = (wr_st == AX_RESP);
   assign s_rvalid_o  = (rd_st == AX_RESP);

   wire aw_now   = s_awvalid_i & s_awready_o;
   wire w_now    = s_wvalid_i & s_wready_o;
   wire aw_have  = aw_held | aw_now;
   wire w_have   = w_held | w_now;
   wire wr_go    = (wr_st == AX_IDLE) & aw_have & w_have;
   wire [ADDR_W-1:0] wa = aw_held ? aw_addr : s_awaddr_i;
   wire [31:0]   wd     = w_held ? w_data : s_wdata_i;
   wire [3:0]    ws     = w_held ? w_strb : s_wstrb_i;
   wire [15:0]   w_idx  = 16'(wa >> 2);
   wire          w_lo   = ws[0];
   wire          w_hi   = ws[1];
   wire [15:0]   w_be   = {{8{w_hi}}, {8{w_lo}}};

   function automatic logic addr_ok(input logic [15:0] idx);
      return (idx == IDX_BUCK3_ON) | (idx == IDX_BUCK3_SLEEP) | (idx == IDX_BOOST_CTRL)
           | (idx == IDX_BOOST_SLEEP) | (idx == IDX_KEY) | (idx == IDX_INT_STATUS)
           | (idx == IDX_INT_MASK) | (idx == IDX_STATUS);
   endfunction : addr_ok

   wire w_on    = wr_go & (w_idx == IDX_BUCK3_ON);
   wire w_slp   = wr_go & (w_idx == IDX_BUCK3_SLEEP);
   wire w_ctrl  = wr_go & (w_idx == IDX_BOOST_CTRL);
   wire w_bslp  = wr_go & (w_idx == IDX_BOOST_SLEEP);
   wire w_key   = wr_go & (w_idx == IDX_KEY) & (ws[1:0] == 2'h3);
   wire w_mask  = wr_go & (w_idx == IDX_INT_MASK);
   wire w_stat  = wr_go & (w_idx == IDX_STATUS);

   // masked merge keeps undefined bits at zero
   wire [15:0] cur_on   = {9'h000, buck3_on_voltage_code};
   wire [15:0] cur_slp  = {9'h000, buck3_sleep_voltage_code};
   wire [15:0] cur_ctrl = {boost_cfg.error_action, 1'b0, boost_cfg.hw_control_source,
                           2'b00, boost_cfg.hw_control_mode, 4'h0,
                           boost_cfg.output_range, 1'b0, boost_cfg.feedback_source};
   wire [15:0] cur_bslp = {7'h00, boost_sleep_enable, 8'h00};
   // the range lane is frozen while locked [RULE10]
   wire [15:0] ctrl_wm  = BOOST_CTRL_MASK & w_be & (key_unlocked ? 16'hFFFF : ~RANGE_FIELD);
   wire [15:0] nx_on    = (cur_on & ~(BUCK3_ON_MASK & w_be)) | (wd[15:0] & BUCK3_ON_MASK & w_be);
   wire [15:0] nx_slp   = (cur_slp & ~(BUCK3_SLEEP_MASK & w_be))
                        | (wd[15:0] & BUCK3_SLEEP_MASK & w_be);               // [RULE13]
   wire [15:0] nx_ctrl  = (cur_ctrl & ~ctrl_wm) | (wd[15:0] & ctrl_wm);     // [RULE13]
   wire [15:0] nx_bslp  = (cur_bslp & ~(BOOST_SLEEP_MASK & w_be))
                        | (wd[15:0] & BOOST_SLEEP_MASK & w_be);

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         wr_st   <= AX_IDLE;
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= '0;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
         s_bresp_o <= 2'h0;
      end else begin
         if (aw_now & ~wr_go) begin
            aw_held <= 1'b1;
            aw_addr <= s_awaddr_i;
         end
         if (w_now & ~wr_go) begin
            w_held <= 1'b1;
            w_data <= s_wdata_i;
            w_strb <= s_wstrb_i;
         end
         if (wr_go) begin
            wr_st   <= AX_RESP;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            s_bresp_o <= addr_ok(w_idx) ? 2'h0 : 2'h2;
         end else if ((wr_st == AX_RESP) & s_bready_i) begin
            wr_st <= AX_IDLE;
         end
      end
   end

   wire [15:0] r_idx  = 16'(s_araddr_i >> 2);
   wire        rd_go  = s_arvalid_i & s_arready_o;
   wire        rd_int = rd_go & (r_idx == IDX_INT_STATUS);
   wire [15:0] status_word = {12'h000, boost_uv_shutdown, boost_on_o, key_unlocked, uv_s[1]};
   wire [15:0] rd_mux =
        (r_idx == IDX_BUCK3_ON)    ? cur_on   :
        (r_idx == IDX_BUCK3_SLEEP) ? cur_slp  :
        (r_idx == IDX_BOOST_CTRL)  ? cur_ctrl :
        (r_idx == IDX_BOOST_SLEEP) ? cur_bslp :
        (r_idx == IDX_INT_STATUS)  ? {14'h0000, int_status} :
        (r_idx == IDX_INT_MASK)    ? {14'h0000, int_mask} :
        (r_idx == IDX_STATUS)      ? status_word : ZERO16;                   // [RULE13]

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         rd_st     <= AX_IDLE;
         s_rdata_o <= 32'h0000_0000;
         s_rresp_o <= 2'h0;
      end else if (rd_go) begin
         rd_st     <= AX_RESP;
         s_rdata_o <= {16'h0000, rd_mux};
         s_rresp_o <= addr_ok(r_idx) ? 2'h0 : 2'h2;
      end else if ((rd_st == AX_RESP) & s_rready_i) begin
         rd_st <= AX_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration fields
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         buck3_on_voltage_code    <= 7'h00;
         buck3_sleep_voltage_code <= 7'h00;                                  // [RULE4]
         boost_cfg                <= bbr_boost_cfg_s'({BOOST_CTRL_RST[15:14],
                                     BOOST_CTRL_RST[12:11], BOOST_CTRL_RST[8],
                                     BOOST_CTRL_RST[3:2], BOOST_CTRL_RST[0]}); // [RULE9] [RULE13]
         boost_sleep_enable       <= 1'b0;                                   // [RULE12]
         boost_software_enable    <= 1'b0;
         key_unlocked             <= 1'b0;
         strap_done               <= 1'b0;
      end else begin
         strap_done <= 1'b1;
         if (~strap_done) begin
            buck3_on_voltage_code <= {nv_s2, 2'b00};                         // [RULE3]
         end else if (w_on) begin
            buck3_on_voltage_code <= nx_on[6:0];
         end
         if (w_slp) buck3_sleep_voltage_code <= nx_slp[6:0];
         if (w_ctrl) begin
            boost_cfg.error_action      <= bbr_err_e'(nx_ctrl[ERR_LSB+:2]);    // [RULE5]
            boost_cfg.hw_control_source <= bbr_src_e'(nx_ctrl[SRC_LSB+:2]);    // [RULE7]
            boost_cfg.hw_control_mode   <= nx_ctrl[MODE_BIT];               // [RULE8]
            boost_cfg.output_range      <= nx_ctrl[RANGE_LSB+:2];           // [RULE10]
            boost_cfg.feedback_source   <= nx_ctrl[FB_BIT];                 // [RULE11]
         end
         if (w_bslp) boost_sleep_enable <= nx_bslp[SLPEN_BIT];
         if (w_stat & w_lo) boost_software_enable <= wd[0];
         // key unlocks one subsequent boost control write; any other key value relocks
         if (w_key) key_unlocked <= (wd[15:0] == USER_KEY);                  // [RULE10]
         else if (w_ctrl) key_unlocked <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // converter control and interrupts
   wire hw_asserted = (boost_cfg.hw_control_source == SRC_HW1) ? hw1_s[1] :
                      (boost_cfg.hw_control_source == SRC_HW2) ? hw2_s[1] :
                      (boost_cfg.hw_control_source == SRC_ANY) ? (hw1_s[1] | hw2_s[1]) :
                      1'b0;                                                  // [RULE7]
   wire hw_off      = boost_cfg.hw_control_mode & hw_asserted;              // [RULE8]
   wire sleep_off   = slp_s[1] & ~boost_sleep_enable;                       // [RULE12]
   wire uv_shut_ev  = uv_event & (boost_cfg.error_action == ERR_SHUTDOWN);  // [RULE5]

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         int_status        <= 2'b00;
         int_mask          <= 2'b00;
         boost_uv_shutdown <= 1'b0;
         boost_on_o        <= 1'b0;
         device_reset_o    <= 1'b0;
      end else begin
         // set wins over the clear by read; bit0 uv event, bit1 device reset
         int_status <= (rd_int ? 2'b00 : int_status)
                     | {uv_event & (boost_cfg.error_action == ERR_RESET), uv_event}; // [RULE6]
         if (w_mask & w_lo) int_mask <= wd[1:0];
         if (uv_shut_ev) boost_uv_shutdown <= 1'b1;
         else if (w_stat & w_lo & ~wd[0]) boost_uv_shutdown <= 1'b0;
         boost_on_o     <= boost_software_enable & ~hw_off & ~sleep_off
                         & ~boost_uv_shutdown & ~uv_shut_ev;
         device_reset_o <= uv_event & (boost_cfg.error_action == ERR_RESET); // [RULE5]
      end
   end

   assign irq_o = |(int_status & ~int_mask);

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         buck3_on_voltage_code_o <= 7'h00;
         buck3_on_mv_o           <= 12'h000;
         buck3_sleep_mv_o        <= 12'h000;
         boost_output_range_o    <= 2'b01;
         boost_feedback_source_o <= 1'b0;
      end else begin
         buck3_on_voltage_code_o <= buck3_on_voltage_code;
         buck3_on_mv_o           <= code_to_mv(buck3_on_voltage_code);      // [RULE1] [RULE2]
         buck3_sleep_mv_o        <= code_to_mv(buck3_sleep_voltage_code);   // [RULE4]
         boost_output_range_o    <= boost_cfg.output_range;
         boost_feedback_source_o <= boost_cfg.feedback_source;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   uv_irq_set_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)  // [RULE6]
      uv_event |=> int_status[0]) else $error("uv event did not set status");
   sat_max_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)     // [RULE2]
      (buck3_on_voltage_code > VCODE_MAX) |=> (buck3_on_mv_o == 12'd3400))
      else $error("code above 65h not saturated");
   lin_map_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)     // [RULE4]
      (buck3_sleep_voltage_code <= VCODE_MAX) |=>
      (buck3_sleep_mv_o == 12'(850 + 25 * $past(buck3_sleep_voltage_code))))
      else $error("sleep code map wrong");
   range_lock_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)  // [RULE10]
      (~key_unlocked) |=> $stable(boost_cfg.output_range))
      else $error("range changed while locked");
   hw_force_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)    // [RULE8]
      (boost_cfg.hw_control_mode & hw_asserted) |=> ~boost_on_o)
      else $error("boost on while hw control asserted");
   sleep_off_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)   // [RULE12]
      (slp_s[1] & ~boost_sleep_enable) |=> ~boost_on_o)
      else $error("boost on in sleep while disabled");
   err_reset_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)   // [RULE5]
      (uv_event & boost_cfg.error_action == ERR_RESET) |=> device_reset_o)
      else $error("reset action missing");
   ign_quiet_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)   // [RULE6]
      (uv_event & boost_cfg.error_action == ERR_IGNORE) |=> ~device_reset_o ##0 int_status[0])
      else $error("ignore action misbehaved");
   rsv_zero_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)    // [RULE13]
      s_rvalid_o |-> (s_rdata_o[31:16] == 16'h0000))
      else $error("upper read bits not zero");
   nv_load_a: assert property (@(posedge ref_clk_i)                         // [RULE3]
      $fell(srst_i) |=> (buck3_on_voltage_code[1:0] == 2'b00))
      else $error("low code bits loaded from strap");
   fb_src_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)      // [RULE11]
      (w_ctrl & w_lo) |=> (boost_cfg.feedback_source == $past(wd[FB_BIT])))
      else $error("feedback source write lost");
   src_any_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)     // [RULE7]
      ((boost_cfg.hw_control_source == SRC_ANY) & boost_cfg.hw_control_mode
       & (hw1_s[1] | hw2_s[1])) |=> ~boost_on_o)
      else $error("either-input source did not force off");

endmodule : bbr_regs
`default_nettype wire

// [dv/tb_bbr_regs.sv]
// tb_bbr_regs: self-checking bench for the buck3/boost register bank.
// assumes bbr_pkg register indices and a single 10 MHz clock; drives AXI4-Lite directly.
`default_nettype none
module tb_bbr_regs
   import bbr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic              ref_clk_i, srst_i;
   logic [ADDR_W-1:0] s_awaddr_i, s_araddr_i;
   logic              s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i;
   logic [31:0]       s_wdata_i;
   logic [3:0]        s_wstrb_i;
   logic              s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
   logic [1:0]        s_bresp_o, s_rresp_o, boost_output_range_o;
   logic [31:0]       s_rdata_o, rd;
   logic [1:0]        rsp;
   logic [4:0]        nv_on_code_i;
   logic              hw_control_1_i, hw_control_2_i, boost_uv_i, sleep_i;
   logic [6:0]        buck3_on_voltage_code_o;
   logic [11:0]       buck3_on_mv_o, buck3_sleep_mv_o;
   logic              boost_feedback_source_o, boost_on_o, device_reset_o, irq_o;
   int                bad_count, checks, cycles;

   bbr_regs u_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .s_awaddr_i(s_awaddr_i),
      .s_awvalid_i(s_awvalid_i), .s_awready_o(s_awready_o), .s_wdata_i(s_wdata_i),
      .s_wstrb_i(s_wstrb_i), .s_wvalid_i(s_wvalid_i), .s_wready_o(s_wready_o),
      .s_bresp_o(s_bresp_o), .s_bvalid_o(s_bvalid_o), .s_bready_i(s_bready_i),
      .s_araddr_i(s_araddr_i), .s_arvalid_i(s_arvalid_i), .s_arready_o(s_arready_o),
      .s_rdata_o(s_rdata_o), .s_rresp_o(s_rresp_o), .s_rvalid_o(s_rvalid_o),
      .s_rready_i(s_rready_i), .nv_on_code_i(nv_on_code_i), .hw_control_1_i(hw_control_1_i),
      .hw_control_2_i(hw_control_2_i), .boost_uv_i(boost_uv_i), .sleep_i(sleep_i),
      .buck3_on_voltage_code_o(buck3_on_voltage_code_o), .buck3_on_mv_o(buck3_on_mv_o),
      .buck3_sleep_mv_o(buck3_sleep_mv_o), .boost_output_range_o(boost_output_range_o),
      .boost_feedback_source_o(boost_feedback_source_o), .boost_on_o(boost_on_o),
      .device_reset_o(device_reset_o), .irq_o(irq_o));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      if (bad_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         bad_count++;
      end
   endtask : chk

   // expected target in mV, worked out independently of the design
   function automatic logic [31:0] mv(input logic [6:0] c);
      return (c >= 7'h66) ? 32'd3400 : 32'd850 + 32'd25 * c;
   endfunction : mv

   function automatic logic [15:0] ctl(input logic [1:0] e, input logic [1:0] s,
                                       input logic m, input logic f);
      return {e, 1'b0, s, 2'b00, m, 4'h0, 2'b01, 1'b0, f};
   endfunction : ctl

   task automatic settle;
      repeat (6) @(posedge ref_clk_i);
   endtask : settle

   ////////////////////////////////////////////////////////////////////////////////
   // each task is entered just after a rising edge
   task automatic wr(input logic [15:0] idx, input logic [15:0] d);
      logic a, w;
      a = 0;
      w = 0;
      s_awaddr_i <= {idx, 2'b00};
      s_wdata_i <= {16'h0000, d};
      s_awvalid_i <= 1'b1;
      s_wvalid_i <= 1'b1;
      s_bready_i <= 1'b1;
      while (!(a && w)) begin
         @(posedge ref_clk_i);
         if (s_awvalid_i && s_awready_o) begin
            a = 1;
            s_awvalid_i <= 1'b0;
         end
         if (s_wvalid_i && s_wready_o) begin
            w = 1;
            s_wvalid_i <= 1'b0;
         end
      end
      do @(posedge ref_clk_i); while (s_bvalid_o !== 1'b1);
      // bready stays up, so a following call never drives it twice in one step
      rsp = s_bresp_o;
   endtask : wr

   task automatic rdr(input logic [15:0] idx);
      s_araddr_i <= {idx, 2'b00};
      s_arvalid_i <= 1'b1;
      s_rready_i <= 1'b1;
      do @(posedge ref_clk_i); while (s_arready_o !== 1'b1);
      s_arvalid_i <= 1'b0;
      do @(posedge ref_clk_i); while (s_rvalid_o !== 1'b1);
      rd = s_rdata_o;
      rsp = s_rresp_o;
   endtask : rdr

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rdr(IDX_BUCK3_ON);    chk(rd, 32'h0000_0054);
      rdr(IDX_BUCK3_SLEEP); chk(rd, 32'h0000_0000);
      rdr(IDX_BOOST_CTRL);  chk(rd, 32'h0000_0104);
      rdr(IDX_BOOST_SLEEP); chk(rd, 32'h0000_0000);
      chk({30'h0, boost_output_range_o}, 32'h1);
      chk({31'h0, boost_feedback_source_o}, 32'h0);
      chk({20'h0, buck3_sleep_mv_o}, mv(7'h00));
   endtask : t_reset

   task automatic t_vcode;
      logic [6:0] c [5];
      c = '{7'h00, 7'h01, 7'h65, 7'h66, 7'h7F};
      foreach (c[i]) begin
         wr(IDX_BUCK3_ON, {9'h000, c[i]});
         wr(IDX_BUCK3_SLEEP, {9'h1FF, c[i]});
         settle();
         chk({25'h0, buck3_on_voltage_code_o}, {25'h0, c[i]});
         chk({20'h0, buck3_on_mv_o}, mv(c[i]));
         chk({20'h0, buck3_sleep_mv_o}, mv(c[i]));
         rdr(IDX_BUCK3_SLEEP); chk(rd, {25'h0, c[i]});
      end
   endtask : t_vcode

   task automatic t_key;
      wr(IDX_BOOST_CTRL, 16'hFFFF);
      rdr(IDX_BOOST_CTRL); chk(rd, 32'h0000_D905);
      wr(IDX_KEY, USER_KEY);
      wr(IDX_BOOST_CTRL, 16'h0109);
      rdr(IDX_BOOST_CTRL); chk(rd, 32'h0000_0109);
      chk({30'h0, boost_output_range_o}, 32'h2);
      chk({31'h0, boost_feedback_source_o}, 32'h1);
      wr(IDX_BOOST_CTRL, 16'h0100);
      rdr(IDX_BOOST_CTRL); chk(rd, 32'h0000_0108);
      rdr(16'h4066); chk({30'h0, rsp}, 32'h2);
      chk(rd, 32'h0);
      wr(16'h4066, 16'hFFFF); chk({30'h0, rsp}, 32'h2);
   endtask : t_key

   task automatic t_hwc;
      for (int s = 0; s < 4; s++) begin
         wr(IDX_BOOST_CTRL, ctl(2'b00, s[1:0], 1'b1, 1'b0));
         wr(IDX_STATUS, 16'h0001);
         hw_control_1_i <= 1'b1;
         hw_control_2_i <= 1'b0;
         settle();
         chk({31'h0, boost_on_o}, {31'h0, !s[0]});
         hw_control_1_i <= 1'b0;
         hw_control_2_i <= 1'b1;
         settle();
         chk({31'h0, boost_on_o}, {31'h0, !s[1]});
      end
      wr(IDX_BOOST_CTRL, ctl(2'b00, 2'b11, 1'b0, 1'b0));
      settle();
      chk({31'h0, boost_on_o}, 32'h1);
      hw_control_2_i <= 1'b0;
   endtask : t_hwc

   task automatic t_uv;
      int p;
      for (int e = 0; e < 3; e++) begin
         wr(IDX_BOOST_CTRL, ctl(e[1:0], 2'b00, 1'b0, 1'b0));
         wr(IDX_STATUS, 16'h0000);
         wr(IDX_STATUS, 16'h0001);
         p = 0;
         boost_uv_i <= 1'b1;
         repeat (8) begin
            @(posedge ref_clk_i);
            if (device_reset_o === 1'b1) p++;
         end
         chk(p, (e == 2) ? 1 : 0);
         chk({31'h0, irq_o}, 32'h1);
         chk({31'h0, boost_on_o}, {31'h0, e != 1});
         rdr(IDX_INT_STATUS); chk(rd, (e == 2) ? 32'h3 : 32'h1);
         boost_uv_i <= 1'b0;
         settle();
         chk({31'h0, irq_o}, 32'h0);
      end
      wr(IDX_BOOST_CTRL, ctl(2'b00, 2'b00, 1'b0, 1'b0));
      wr(IDX_INT_MASK, 16'h0003);
      boost_uv_i <= 1'b1;
      settle();
      chk({31'h0, irq_o}, 32'h0);
      wr(IDX_INT_MASK, 16'h0000);
      settle();
      chk({31'h0, irq_o}, 32'h1);
      rdr(IDX_INT_STATUS);
      boost_uv_i <= 1'b0;
   endtask : t_uv

   task automatic t_sleep;
      wr(IDX_STATUS, 16'h0000);
      wr(IDX_STATUS, 16'h0001);
      sleep_i <= 1'b1;
      settle();
      chk({31'h0, boost_on_o}, 32'h0);
      wr(IDX_BOOST_SLEEP, 16'hFFFF);
      settle();
      chk({31'h0, boost_on_o}, 32'h1);
      rdr(IDX_BOOST_SLEEP); chk(rd, 32'h0000_0100);
      sleep_i <= 1'b0;
   endtask : t_sleep

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end

   // the whole run needs a few hundred cycles; the ceiling leaves wide margin
   initial begin
      cycles = 0;
      forever begin
         @(posedge ref_clk_i);
         cycles++;
         if (cycles == 20000) begin
            bad_count++;
            close_out();
         end
      end
   end

   initial begin
      bad_count = 0;
      checks = 0;
      srst_i = 1'b1;
      {s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i} = 5'h00;
      s_awaddr_i = '0;
      s_araddr_i = '0;
      s_wdata_i = 32'h0;
      s_wstrb_i = 4'hF;
      nv_on_code_i = 5'h15;
      {hw_control_1_i, hw_control_2_i, boost_uv_i, sleep_i} = 4'h0;
      repeat (16) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      t_reset();
      t_vcode();
      t_key();
      t_hwc();
      t_uv();
      t_sleep();
      close_out();
   end
endmodule : tb_bbr_regs
`default_nettype wire
